// [hw/ihx_consts.vh]
// Shared constants for the I2C host transfer and arbitration block.
// Assumes inclusion by bare name from the design files.
`ifndef IHX_CONSTS_VH
`define IHX_CONSTS_VH
// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define IHX_BAUD_RESET   8'h13
`define IHX_BAUD_MIN     8'h03
`define IHX_BITS_BYTE    4'h8
`define IHX_BIT_ACK      4'h9
`define IHX_SYNC_STAGES  2
`endif

// [hw/ihx_baud_gen.v]
// Reload-based baud counter giving one pulse per baud period.
// Assumes reload value is stable while a transfer runs.
`timescale 1ns/1ps
`include "ihx_consts.vh"
module ihx_baud_gen #(
  parameter WIDTH = 8
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             run,
  input  wire             reload,
  input  wire [WIDTH-1:0] reloadValue,
  output reg              rollover
);
  reg [WIDTH-1:0] count_q;
  // ----------------------------------------
  // Count down, reload on demand or rollover
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count_q  <= {WIDTH{1'b0}};
      rollover <= 1'b0;
    end
    else
    begin
      rollover <= 1'b0;
      if (reload || !run)
        count_q <= reloadValue;
      else if (count_q == {WIDTH{1'b0}})
      begin
        count_q  <= reloadValue;
        rollover <= 1'b1;
      end
      else
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // ihx_baud_gen

// [hw/ihx_host.v]
// I2C host byte engine with collision and bus-free tracking.
// Assumes open-drain pins resolved outside; control bits are pulses/levels from software.
`timescale 1ns/1ps
`include "ihx_consts.vh"
module ihx_host #(
  parameter BAUD_WIDTH = 8
) (
  input  wire                  sys_clk,
  input  wire                  rst,
  input  wire                  portEnable,
  input  wire [BAUD_WIDTH-1:0] baudReloadValue,
  input  wire                  bufWrite,
  input  wire [7:0]            bufWriteData,
  input  wire                  bufRead,
  output reg  [7:0]            serialDataBuffer,
  input  wire                  startRequestSet,
  input  wire                  restartRequestSet,
  input  wire                  stopRequestSet,
  input  wire                  receiveRequestSet,
  input  wire                  ackSequenceRequestSet,
  input  wire                  ackValueBit,
  input  wire                  writeCollisionClear,
  input  wire                  portInterruptClear,
  input  wire                  busCollisionClear,
  input  wire                  overflowClear,
  output reg                   startRequest,
  output reg                   restartRequest,
  output reg                   stopRequest,
  output reg                   receiveRequest,
  output reg                   ackSequenceRequest,
  output reg                   bufferFullFlag,
  output reg                   writeCollisionFlag,
  output reg                   receiveOverflowFlag,
  output reg                   ackStatusBit,
  output reg                   portInterruptFlag,
  output reg                   busCollisionFlag,
  output reg                   startSeen,
  output reg                   stopSeen,
  output wire                  sclOut,
  output wire                  sclOe,
  input  wire                  sclIn,
  output wire                  sdaOut,
  output wire                  sdaOe
  ,input wire                  sdaIn
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_RSTRT = 3'h2;
  localparam [2:0] ST_XMIT  = 3'h3;
  localparam [2:0] ST_RECV  = 3'h4;
  localparam [2:0] ST_ACK   = 3'h5;
  localparam [2:0] ST_STOP  = 3'h6;

  reg [2:0] state_q;
  reg [2:0] phase_q;      // Sub-step inside a condition
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg       sclLow_q;     // 1 = drive SCL low
  reg       sdaLow_q;     // 1 = drive SDA low
  reg       sclHalf_q;    // 0 = low half of bit, 1 = high half
  reg       waitHigh_q;   // SCL released, waiting for it to read high

  // ----------------------------------------
  // Pin synchronisers (two flops each)
  // ----------------------------------------
  reg [1:0] sclSync_q;
  reg [1:0] sdaSync_q;
  reg       sclPrev_q;
  reg       sdaPrev_q;
  wire      sclHi = sclSync_q[1];
  wire      sdaHi = sdaSync_q[1];
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end

  // Bus conditions seen by any host
  wire busStart = sclHi && sclPrev_q && sdaPrev_q && !sdaHi;
  wire busStop  = sclHi && sclPrev_q && !sdaPrev_q && sdaHi;

  // Open-drain pins: output always 0, enable when pulling low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = sclLow_q;
  assign sdaOe  = sdaLow_q;

  // ----------------------------------------
  // Baud generator, period (reload+1)*... per half bit
  // ----------------------------------------
  wire baudTick;
  wire baudRun    = (state_q != ST_IDLE) && !waitHigh_q;
  wire baudReload = waitHigh_q;
  ihx_baud_gen #(
    .WIDTH (BAUD_WIDTH)
  ) uBaud (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .run         (baudRun),
    .reload      (baudReload),
    .reloadValue (baudReloadValue),
    .rollover    (baudTick)
  );

  wire busy = (state_q != ST_IDLE);
  // Expecting SDA high while SCL high, but another host pulls it low
  // Judged only in the high half: sync lag on a fresh bit and the client ack are not a rival
  wire ackSlot = (state_q == ST_XMIT) && (bitCnt_q == `IHX_BITS_BYTE);
  wire arbLost = sclHalf_q && !ackSlot && !sdaLow_q && sclHi && !sdaHi && !waitHigh_q;

  // ----------------------------------------
  // Main engine
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q             <= ST_IDLE;
      phase_q             <= 3'h0;
      bitCnt_q            <= 4'h0;
      shift_q             <= 8'h00;
      sclLow_q            <= 1'b0;
      sdaLow_q            <= 1'b0;
      sclHalf_q           <= 1'b0;
      waitHigh_q          <= 1'b0;
      serialDataBuffer    <= 8'h00;
      startRequest        <= 1'b0;
      restartRequest      <= 1'b0;
      stopRequest         <= 1'b0;
      receiveRequest      <= 1'b0;
      ackSequenceRequest  <= 1'b0;
      bufferFullFlag      <= 1'b0;
      writeCollisionFlag  <= 1'b0;
      receiveOverflowFlag <= 1'b0;
      ackStatusBit        <= 1'b0;
      portInterruptFlag   <= 1'b0;
      busCollisionFlag    <= 1'b0;
      startSeen           <= 1'b0;
      stopSeen            <= 1'b0;
    end
    else if (!portEnable)
    begin
      state_q        <= ST_IDLE;
      sclLow_q       <= 1'b0;
      sdaLow_q       <= 1'b0;
      waitHigh_q     <= 1'b0;
      startSeen      <= 1'b0;
      stopSeen       <= 1'b0;
      startRequest   <= 1'b0;
      restartRequest <= 1'b0;
      stopRequest    <= 1'b0;
      receiveRequest <= 1'b0;
      ackSequenceRequest <= 1'b0;
    end
    else
    begin
      // Software clears of sticky flags; hardware sets below win
      // no sleep gating, logic keeps running
      if (writeCollisionClear)
        writeCollisionFlag <= 1'b0;
      if (portInterruptClear)
        portInterruptFlag <= 1'b0;
      if (busCollisionClear)
        busCollisionFlag <= 1'b0;
      if (overflowClear)
        receiveOverflowFlag <= 1'b0;
      if (bufRead && state_q != ST_XMIT)
        bufferFullFlag <= 1'b0;

      // bus free tracking and stop interrupt
      if (busStart)
      begin
        startSeen <= 1'b1;
        stopSeen  <= 1'b0;
      end
      if (busStop)
      begin
        stopSeen  <= 1'b1;
        startSeen <= 1'b0;
        if (!busy)
          portInterruptFlag <= 1'b1;
      end

      // write collision on busy buffer write
      if (bufWrite && busy)
        writeCollisionFlag <= 1'b1;

      // wait for released SCL to read high
      if (waitHigh_q && sclHi)
        waitHigh_q <= 1'b0;

      case (state_q)
        ST_IDLE:
        begin
          phase_q <= 3'h0;
          if (bufWrite)
          begin
            serialDataBuffer <= bufWriteData;
            shift_q          <= bufWriteData;
            bufferFullFlag   <= 1'b1;
            bitCnt_q         <= 4'h0;
            sclHalf_q        <= 1'b0;
            sclLow_q         <= 1'b1;
            state_q          <= ST_XMIT;
          end
          else if (startRequestSet)
          begin
            startRequest <= 1'b1;
            if (!sclHi || !sdaHi)
            begin
              busCollisionFlag <= 1'b1;
              startRequest     <= 1'b0;
            end
            else
              state_q <= ST_START;
          end
          else if (restartRequestSet)
          begin
            restartRequest <= 1'b1;
            sclLow_q       <= 1'b1;
            state_q        <= ST_RSTRT;
          end
          else if (stopRequestSet)
          begin
            stopRequest <= 1'b1;
            sdaLow_q    <= 1'b1;
            state_q     <= ST_STOP;
          end
          else if (ackSequenceRequestSet)
          begin
            ackSequenceRequest <= 1'b1;
            sclLow_q           <= 1'b1;
            sdaLow_q           <= !ackValueBit;
            state_q            <= ST_ACK;
          end
          else if (receiveRequestSet)
          begin
            receiveRequest <= 1'b1;
            bitCnt_q       <= 4'h0;
            sclHalf_q      <= 1'b0;
            sclLow_q       <= 1'b1;
            sdaLow_q       <= 1'b0;
            state_q        <= ST_RECV;
          end
        end

        ST_START:
        begin
          if (phase_q == 3'h0 && !sclHi)
          begin
            busCollisionFlag <= 1'b1;
            startRequest     <= 1'b0;
            state_q          <= ST_IDLE;
          end
          else if (baudTick)
          begin
            if (phase_q == 3'h0)
            begin
              sdaLow_q <= 1'b1;
              phase_q  <= 3'h1;
            end
            else
            begin
              sclLow_q          <= 1'b1;
              startRequest      <= 1'b0;
              portInterruptFlag <= 1'b1;
              state_q           <= ST_IDLE;
            end
          end
        end

        ST_XMIT, ST_RECV, ST_ACK, ST_RSTRT, ST_STOP:
        begin
          if (arbLost && (state_q != ST_RECV) && !(state_q == ST_STOP && phase_q == 3'h0))
          begin
            busCollisionFlag   <= 1'b1;
            bufferFullFlag     <= (state_q == ST_XMIT) ? 1'b0 : bufferFullFlag;
            sclLow_q           <= 1'b0;
            sdaLow_q           <= 1'b0;
            restartRequest     <= 1'b0;
            stopRequest        <= 1'b0;
            ackSequenceRequest <= 1'b0;
            state_q            <= ST_IDLE;
          end
          else if (state_q == ST_STOP && phase_q == 3'h1)
          begin
            // Stop done once seen on the bus
            if (busStop)
            begin
              stopRequest       <= 1'b0;
              portInterruptFlag <= 1'b1;
              state_q           <= ST_IDLE;
            end
          end
          else if (baudTick)
          begin
            if (!sclHalf_q)
            begin
              sclLow_q   <= 1'b0;
              waitHigh_q <= 1'b1;
              sclHalf_q  <= 1'b1;
              if (state_q == ST_XMIT && bitCnt_q == `IHX_BITS_BYTE)
                ackStatusBit <= !sdaHi ? 1'b0 : 1'b1;
            end
            else
            begin
              sclLow_q  <= 1'b1;
              sclHalf_q <= 1'b0;
              bitCnt_q  <= bitCnt_q + 4'h1;
              case (state_q)
                ST_XMIT:
                begin
                  if (bitCnt_q == `IHX_BITS_BYTE)
                  begin
                    portInterruptFlag <= 1'b1;
                    state_q           <= ST_IDLE;
                  end
                  else if (bitCnt_q == 4'h7)
                  begin
                    bufferFullFlag <= 1'b0;
                    sdaLow_q       <= 1'b0;
                  end
                  else
                    sdaLow_q <= !shift_q[3'h6 - bitCnt_q[2:0]];
                end
                ST_RECV:
                begin
                  shift_q <= {shift_q[6:0], sdaHi};
                  if (bitCnt_q == 4'h7)
                  begin
                    receiveRequest    <= 1'b0;
                    serialDataBuffer  <= {shift_q[6:0], sdaHi};
                    bufferFullFlag    <= 1'b1;
                    portInterruptFlag <= 1'b1;
                    if (bufferFullFlag && !bufRead)
                      receiveOverflowFlag <= 1'b1;
                    state_q <= ST_IDLE;
                  end
                end
                default:
                begin
                  sdaLow_q           <= (state_q == ST_STOP) ? 1'b0 : sdaLow_q;
                  sclLow_q           <= (state_q == ST_STOP) ? 1'b0 : 1'b1;
                  if (state_q == ST_RSTRT)
                    sdaLow_q <= 1'b1;
                  // Own Stop finishes when seen, so it is not flagged twice
                  if (state_q == ST_STOP)
                    phase_q <= 3'h1;
                  else
                  begin
                    restartRequest     <= 1'b0;
                    ackSequenceRequest <= 1'b0;
                    portInterruptFlag  <= 1'b1;
                    state_q            <= ST_IDLE;
                  end
                end
              endcase
            end
          end
          // First bit placed as transfer starts, while SCL low
          if (state_q == ST_XMIT && bitCnt_q == 4'h0 && !sclHalf_q)
            sdaLow_q <= !shift_q[7];
        end

        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
  // flags other than bufferFullFlag only cleared by software clears above; bufferFullFlag also clears in hardware
endmodule // ihx_host

// [dv/ihx_host_checker.sv]
// Assertions on the host engine ports.
// Assumes a bind onto ihx_host with one clock domain.
`timescale 1ns/1ps
module ihx_host_checker (
  input wire       sys_clk,
  input wire       rst,
  input wire       portEnable,
  input wire       bufWrite,
  input wire [7:0] serialDataBuffer,
  input wire       receiveRequestSet,
  input wire       writeCollisionClear,
  input wire       portInterruptClear,
  input wire       busCollisionClear,
  input wire       startRequest,
  input wire       restartRequest,
  input wire       stopRequest,
  input wire       receiveRequest,
  input wire       ackSequenceRequest,
  input wire       bufferFullFlag,
  input wire       writeCollisionFlag,
  input wire       portInterruptFlag,
  input wire       busCollisionFlag,
  input wire       startSeen,
  input wire       stopSeen,
  input wire       sclOe,
  input wire       sdaOe,
  input wire       sclIn
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Any running condition sequence makes the engine busy
  wire busyReq = startRequest | restartRequest | stopRequest | ackSequenceRequest;

  property p_write_collision_flag_hold; writeCollisionFlag && !writeCollisionClear && portEnable |=> writeCollisionFlag; endproperty
  a_write_collision_flag_hold: assert property (p_write_collision_flag_hold) else $error("write collision lost");
  property p_write_collision_flag_keep; $rose(writeCollisionFlag) |-> $past(bufWrite) && $stable(serialDataBuffer); endproperty
  a_write_collision_flag_keep: assert property (p_write_collision_flag_keep) else $error("refused write stored");
  property p_irq_hold; portInterruptFlag && !portInterruptClear && portEnable |=> portInterruptFlag; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt lost");
  property p_bcl_hold; busCollisionFlag && !busCollisionClear && portEnable |=> busCollisionFlag; endproperty
  a_bcl_hold: assert property (p_bcl_hold) else $error("collision lost");
  property p_rx_ign; receiveRequestSet && busyReq |=> !receiveRequest; endproperty
  a_rx_ign: assert property (p_rx_ign) else $error("receive taken while busy");
  property p_rx_done; $fell(receiveRequest) && portEnable && !busCollisionFlag
    |-> ##[0:2] (bufferFullFlag && portInterruptFlag); endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive end flags");
  property p_bcl_free; $rose(busCollisionFlag) |-> ##[0:3] (!sclOe && !sdaOe && !busyReq && !bufferFullFlag); endproperty
  a_bcl_free: assert property (p_bcl_free) else $error("collision not released");
  property p_seen_clr; !portEnable ##1 !portEnable |-> !startSeen && !stopSeen; endproperty
  a_seen_clr: assert property (p_seen_clr) else $error("seen bits kept");
  property p_stretch; !sclOe && !sclIn && !$past(sclIn) && !$past(sclIn, 2) |=> !sclOe; endproperty
  a_stretch: assert property (p_stretch) else $error("SCL pulled during stretch");
endmodule // ihx_host_checker

// [dv/ihx_bus_model.sv]
// Far side of the bus: pull-ups, one client and a rival host.
// Assumes host pins as pull-low enables; the bench steers the client.
`timescale 1ns/1ps
module ihx_bus_model (
  input  wire       sys_clk,
  input  wire       sclOe,
  input  wire       sdaOe,
  input  wire       rxMode,
  input  wire       giveAck,
  input  wire [7:0] rxByte,
  input  wire [7:0] stretch,
  input  wire       frameClr,
  input  wire       rivalScl,
  input  wire       rivalSda,
  output wire       sclIn,
  output wire       sdaIn
);
  reg       sclPrev = 1'b1;
  reg [3:0] fallCnt = 4'h0;
  reg [7:0] holdCnt = 8'h00;
  wire      cliSda;
  // Released lines float to the pull-up level, never a stale value
  assign sclIn = ~(sclOe | rivalScl | (holdCnt != 8'h00));
  assign sdaIn = ~(sdaOe | rivalSda | cliSda);
  assign cliSda = rxMode ? (fallCnt < 4'h8 && !rxByte[3'h7 - fallCnt[2:0]]) : (giveAck && fallCnt == 4'h8);
  always @(posedge sys_clk)
  begin
    sclPrev <= sclIn;
    if (frameClr)
      fallCnt <= 4'h0;
    else if (sclPrev && !sclIn)
    begin
      fallCnt <= fallCnt + 4'h1;
      holdCnt <= stretch;
    end
    else if (holdCnt != 8'h00)
      holdCnt <= holdCnt - 8'h01;
  end
endmodule // ihx_bus_model

// [dv/ihx_tb.sv]
// Bench for the host byte engine with a bus model.
// Assumes the checker is bound below; one 50 MHz clock.
`timescale 1ns/1ps
module testbench;
  localparam [7:0] RELOAD = 8'h03;
  reg        sys_clk = 1'b0;
  reg        rst = 1'b1;
  reg        portEnable = 1'b1;
  reg  [7:0] baudReloadValue = RELOAD;
  reg        bufWrite = 1'b0;
  reg  [7:0] bufWriteData = 8'h00;
  reg        bufRead = 1'b0;
  reg        ackValueBit = 1'b0;
  reg  [8:0] ctl = 9'h000;
  reg        rxMode = 1'b0;
  reg        giveAck = 1'b1;
  reg  [7:0] rxByte = 8'h00;
  reg  [7:0] stretch = 8'h00;
  reg        frameClr = 1'b0;
  reg        rivalScl = 1'b0;
  reg        rivalSda = 1'b0;
  reg  [8:0] bitLog = 9'h000;
  reg  [7:0] highCnt = 8'h00;
  reg  [7:0] lastHigh = 8'h00;
  integer    bad_count = 0;
  integer    checks = 0;
  integer    cycles = 0;
  integer    i;
  wire [7:0] serialDataBuffer;
  wire       ackSequenceRequestSet, receiveRequestSet, stopRequestSet, restartRequestSet, startRequestSet;
  wire       overflowClear, busCollisionClear, portInterruptClear, writeCollisionClear;
  wire       startRequest, restartRequest, stopRequest, receiveRequest, ackSequenceRequest;
  wire       bufferFullFlag, writeCollisionFlag, receiveOverflowFlag, ackStatusBit, portInterruptFlag;
  wire       busCollisionFlag, startSeen, stopSeen, sclOut, sclOe, sclIn, sdaOut, sdaOe, sdaIn;
  // One-hot control pulses: 0..3 clears, 4 start, 5 restart, 6 stop, 7 receive, 8 ack
  assign {ackSequenceRequestSet, receiveRequestSet, stopRequestSet, restartRequestSet, startRequestSet,
          overflowClear, busCollisionClear, portInterruptClear, writeCollisionClear} = ctl;
  ihx_host ihx_host_i (.*);
  ihx_bus_model ihx_bus_model_i (.*);
  always #10 sys_clk = ~sys_clk;
  // Wire log: SDA at each SCL rise, length of each SCL high phase
  always @(posedge sclIn)
    bitLog = {bitLog[7:0], sdaIn};
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (sclIn)
      highCnt <= highCnt + 8'h01;
    else if (highCnt != 8'h00)
    begin
      lastHigh <= highCnt;
      highCnt  <= 8'h00;
    end
    // Hang guard, far above the thousand or so cycles the tests need
    if (cycles == 30000)
    begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  // ----------
  // Tasks
  // ----------
  task chk(input [79:0] name, input [7:0] exp, input [7:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("mismatch %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task pulse(input integer k);
  begin
    @(negedge sys_clk);
    ctl = 9'h001 << k;
    frameClr = (k == 7);
    @(negedge sys_clk);
    ctl = 9'h000;
    frameClr = 1'b0;
  end
  endtask
  // Buffer write (w=1) or read (w=0); a write also restarts the client's bit count
  task acc(input w, input [7:0] d);
  begin
    @(negedge sys_clk);
    bufWrite = w;
    bufRead = !w;
    bufWriteData = d;
    frameClr = w;
    @(negedge sys_clk);
    bufWrite = 1'b0;
    bufRead = 1'b0;
    frameClr = 1'b0;
  end
  endtask
  // Bounded wait on the interrupt (0) or collision (1) flag, then clear it
  task wait_flag(input sel);
  begin
    i = 0;
    while ((sel ? busCollisionFlag : portInterruptFlag) !== 1'b1 && i < 3000)
    begin
      @(negedge sys_clk);
      i = i + 1;
    end
    chk("flag", 8'h01, sel ? busCollisionFlag : portInterruptFlag);
    pulse(sel ? 2 : 1);
  end
  endtask
  task report_and_stop;
  begin
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  // ----------
  // Tests
  // ----------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk("sclOe", 8'h00, sclOe);
    pulse(4);
    pulse(7);
    chk("rxReq", 8'h00, receiveRequest);
    wait_flag(0);
    chk("sSeen", 8'h01, startSeen);
    acc(1, 8'hA4);
    chk("bf", 8'h01, bufferFullFlag);
    acc(1, 8'h11);
    chk("write_collision_flag", 8'h01, writeCollisionFlag);
    chk("buf", 8'hA4, serialDataBuffer);
    wait_flag(0);
    chk("byte", 8'hA4, bitLog[8:1]);
    chk("ackSt", 8'h00, ackStatusBit);
    chk("bf", 8'h00, bufferFullFlag);
    chk("hold", 8'h01, sclOe);
    chk("write_collision_flag", 8'h01, writeCollisionFlag);
    chk("high", 8'h01, lastHigh >= RELOAD + 8'h01 && lastHigh <= RELOAD + 8'h06);
    pulse(0);
    chk("write_collision_flag", 8'h00, writeCollisionFlag);
    giveAck = 1'b0;
    stretch = 8'h1E;
    acc(1, 8'h5B);
    wait_flag(0);
    chk("byte", 8'h5B, bitLog[8:1]);
    chk("ackSt", 8'h01, ackStatusBit);
    stretch = 8'h00;
    giveAck = 1'b1;
    pulse(6);
    wait_flag(0);
    chk("pSeen", 8'h01, stopSeen);
    chk("sdaOe", 8'h00, sdaOe);
    pulse(4);
    wait_flag(0);
    acc(1, 8'hA5);
    wait_flag(0);
    rxMode = 1'b1;
    rxByte = 8'h3C;
    pulse(7);
    acc(1, 8'h22);
    chk("write_collision_flag", 8'h01, writeCollisionFlag);
    pulse(0);
    wait_flag(0);
    chk("buf", 8'h3C, serialDataBuffer);
    chk("bf", 8'h01, bufferFullFlag);
    chk("rxReq", 8'h00, receiveRequest);
    rxByte = 8'hC3;
    pulse(7);
    wait_flag(0);
    chk("ovf", 8'h01, receiveOverflowFlag);
    acc(0, 8'h00);
    chk("bf", 8'h00, bufferFullFlag);
    pulse(8);
    wait_flag(0);
    chk("ackBit", 8'h00, bitLog[0]);
    rxMode = 1'b0;
    pulse(6);
    wait_flag(0);
    pulse(4);
    wait_flag(0);
    acc(1, 8'hFF);
    rivalSda = 1'b1;
    wait_flag(1);
    chk("bf", 8'h00, bufferFullFlag);
    chk("lines", 8'h00, {sclOe, sdaOe});
    rivalSda = 1'b0;
    wait_flag(0);
    giveAck = 1'b0;
    acc(1, 8'h81);
    chk("write_collision_flag", 8'h00, writeCollisionFlag);
    wait_flag(0);
    chk("byte", 8'h81, bitLog[8:1]);
    giveAck = 1'b1;
    pulse(6);
    wait_flag(0);
    rivalScl = 1'b1;
    pulse(4);
    wait_flag(1);
    chk("sReq", 8'h00, startRequest);
    rivalScl = 1'b0;
    portEnable = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("seen", 8'h00, {startSeen, stopSeen});
    report_and_stop;
  end
endmodule // testbench
bind ihx_host ihx_host_checker ihx_host_checker_i (.*);
